// ### logic/plc_ctrl.sv
// Program level priority controller with per-level register banks and status word
`timescale 1ns/1ps
`include "plc_regs.svh"
module plc_ctrl (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic [3:0] addr_i,
    input wire plc_pkg::plc_word_t wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output plc_pkg::plc_word_t rdata_o,
    input wire logic vec_req_i,
    input wire plc_pkg::plc_level_t vec_level_i,
    input wire plc_pkg::plc_vector_t vec_id_i,
    input wire logic int_status_i,
    input wire logic instr_boundary_i,
    output plc_pkg::plc_level_t current_level_o,
    output logic switching_o,
    output plc_pkg::plc_vector_t last_vector_o,
    output plc_pkg::plc_word_t processor_status_word_o,
    output logic irq_o
);
    import plc_pkg::*;

    // Banks live inside the state record and are indexed by the running
    // level, so a context switch moves only the level number and copies nothing
    typedef struct packed {
        plc_word_t enable;
        plc_word_t request;
        plc_word_t [15:0] flags;
        plc_word_t [15:0][7:0] greg;
        logic [2:0] gsel;
        plc_level_t level;
        plc_state_t state;
        logic [4:0] cnt;
        logic sw;
        plc_word_t psw;
        plc_word_t rdata;
        plc_vector_t vec;
        logic [1:0] evt;
        logic [1:0] evt_mask;
        logic [1:0] vs;
        logic [1:0] is;
        logic vs_d;
        logic is_d;
        plc_level_t vl_s1;
        plc_level_t vl_s2;
        plc_vector_t vi_s1;
        plc_vector_t vi_s2;
        logic irq;
    } plc_state_s_t;

    localparam plc_word_t EXT_MASK = `PLC_EXT_LEVELS;

    plc_state_s_t s_r;
    plc_state_s_t s_nxt;

    function automatic plc_level_t plc_highest(input plc_word_t m);
        plc_level_t h;
        h = 4'h0;
        for (int i = 0; i < 16; i++) begin
            if (m[i]) begin
                h = plc_level_t'(i);
            end
        end
        return h;
    endfunction : plc_highest

    function automatic plc_word_t plc_onehot(input plc_level_t l);
        return plc_word_t'(16'h0001 << l);
    endfunction : plc_onehot

    // Status word of one level: its flags, its number in the level field,
    // and the spare bits forced to zero whatever software stored there
    function automatic plc_word_t plc_status_word(input plc_word_t f, input plc_level_t l);
        plc_word_t w;
        w = (f & `PLC_FLAG_MASK) | (plc_word_t'(l) << `PLC_LVL_LSB); // R15 R14
        w[`PLC_MMU_BIT] = f[`PLC_MMU_BIT]; // R17
        w[`PLC_IRQ_BIT] = f[`PLC_IRQ_BIT]; // R16
        return w;
    endfunction : plc_status_word

    plc_word_t eligible;
    plc_level_t best;
    plc_word_t sts_view;
    plc_word_t vec_hit;
    logic vec_rise;
    logic int_rise;

    // Edges are taken from the second synchroniser stage only
    assign vec_rise = s_r.vs[1] & ~s_r.vs_d;
    assign int_rise = s_r.is[1] & ~s_r.is_d;

    // One decoder per level; requests aimed at a level outside the device
    // set are dropped here, so level 14 stays private to internal events
    for (genvar g = 0; g < 16; g++) begin : g_vec_hit
        assign vec_hit[g] = vec_rise & EXT_MASK[g] & (s_r.vl_s2 == 4'(g)); // R5
    end

    always_comb begin
        s_nxt = s_r;
        eligible = s_r.enable & s_r.request; // R8
        best = plc_highest(eligible); // R10 R2
        sts_view = plc_status_word(s_r.flags[s_r.level], s_r.level); // R14 R15
        // Pin synchronisers: only the second stage is read
        s_nxt.vs = {s_r.vs[0], vec_req_i};
        s_nxt.is = {s_r.is[0], int_status_i};
        s_nxt.vl_s1 = vec_level_i;
        s_nxt.vl_s2 = s_r.vl_s1;
        s_nxt.vi_s1 = vec_id_i;
        s_nxt.vi_s2 = s_r.vi_s1;
        s_nxt.vs_d = s_r.vs[1];
        s_nxt.is_d = s_r.is[1];
        // Register writes
        s_nxt.rdata = 16'h0000;
        if (wr_i) begin
            unique case (addr_i)
                `PLC_ADDR_ENABLE: begin
                    s_nxt.enable = wdata_i; // R9
                end
                `PLC_ADDR_REQUEST: begin
                    s_nxt.request = wdata_i; // R4 R9
                end
                `PLC_ADDR_SET_REQ: begin
                    s_nxt.request = s_r.request | wdata_i; // R4
                end
                `PLC_ADDR_CLR_REQ: begin
                    s_nxt.request = s_r.request & ~wdata_i;
                end
                `PLC_ADDR_GIVE_UP: begin
                    s_nxt.request[s_r.level] = 1'b0; // R12
                end
                `PLC_ADDR_STATUS: begin
                    s_nxt.flags[s_r.level] = wdata_i;
                end
                `PLC_ADDR_EVT_MASK: begin
                    s_nxt.evt_mask = wdata_i[1:0];
                end
                `PLC_ADDR_GSEL: begin
                    s_nxt.gsel = wdata_i[2:0];
                end
                `PLC_ADDR_GREG: begin
                    s_nxt.greg[s_r.level][s_r.gsel] = wdata_i; // R13 R1
                end
                default: begin
                end
            endcase
        end
        // Register reads, answered one cycle later
        if (rd_i) begin
            unique case (addr_i)
                `PLC_ADDR_ENABLE: begin
                    s_nxt.rdata = s_r.enable;
                end
                `PLC_ADDR_REQUEST: begin
                    s_nxt.rdata = s_r.request;
                end
                `PLC_ADDR_STATUS: begin
                    s_nxt.rdata = sts_view;
                end
                `PLC_ADDR_EVT: begin
                    s_nxt.rdata = {14'h0000, s_r.evt};
                end
                `PLC_ADDR_EVT_MASK: begin
                    s_nxt.rdata = {14'h0000, s_r.evt_mask};
                end
                `PLC_ADDR_LEVEL: begin
                    s_nxt.rdata = {12'h000, s_r.level};
                end
                `PLC_ADDR_GSEL: begin
                    s_nxt.rdata = {13'h0000, s_r.gsel};
                end
                `PLC_ADDR_GREG: begin
                    s_nxt.rdata = s_r.greg[s_r.level][s_r.gsel]; // R13
                end
                default: begin
                    s_nxt.rdata = 16'h0000;
                end
            endcase
            if (addr_i == `PLC_ADDR_EVT) begin
                s_nxt.evt = 2'b00;
            end
        end
        // Hardware sets come after the software strobes so that they win
        if (vec_hit != 16'h0000) begin
            s_nxt.request = s_nxt.request | vec_hit; // R9 R11
            s_nxt.vec = s_r.vi_s2; // R7
            s_nxt.evt[0] = 1'b1;
        end
        if (int_rise) begin
            s_nxt.request[`PLC_INT_LEVEL] = 1'b1; // R6
        end
        // Context switch; the winner is looked at again when the switch ends
        unique case (s_r.state)
            PLC_RUN: begin
                if (best != s_r.level && instr_boundary_i) begin // R18
                    s_nxt.cnt = 5'h00;
                    s_nxt.state = PLC_SWITCH;
                end
            end
            PLC_SWITCH: begin
                if (s_r.cnt == 5'(`PLC_SWITCH_LAST)) begin // R3
                    s_nxt.level = best; // R10 R11 R12
                    s_nxt.evt[1] = 1'b1;
                    s_nxt.state = PLC_RUN;
                end else begin
                    s_nxt.cnt = s_r.cnt + 5'h01;
                end
            end
            default: begin
                s_nxt.state = PLC_RUN;
            end
        endcase
        // Outputs are built from the next state: each pin is a flop, yet the
        // status word and the level pins always agree in the same cycle
        s_nxt.sw = (s_nxt.state == PLC_SWITCH);
        s_nxt.psw = plc_status_word(s_nxt.flags[s_nxt.level], s_nxt.level); // R14 R15 R16 R17
        s_nxt.irq = |(s_nxt.evt & s_nxt.evt_mask);
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign rdata_o = s_r.rdata;
    assign current_level_o = s_r.level;
    assign switching_o = s_r.sw;
    assign last_vector_o = s_r.vec;
    assign irq_o = s_r.irq;
    assign processor_status_word_o = s_r.psw;
endmodule : plc_ctrl

// ### logic/plc_pkg.sv
// Types of the program level controller
package plc_pkg;
    typedef logic [3:0] plc_level_t;
    typedef logic [15:0] plc_word_t;
    typedef logic [10:0] plc_vector_t;
    typedef enum logic [1:0] {
        PLC_RUN = 2'b00,
        PLC_SWITCH = 2'b01
    } plc_state_t;
endpackage : plc_pkg

// ### logic/plc_regs.svh
// Register map, field positions and timing constants of the program level controller
// Behaviour
// (R1) Sixteen levels, each with private registers
// (R2) Levels 0..15, higher number more urgent
// (R3) Automatic context switch within one microsecond
// (R4) Software may activate any level
// (R5) External requests only levels 10-13, 15
// (R6) Level 14 taken by internal status events
// (R7) Up to 2048 vectored sources accepted
// (R8) Enable and detect masks, bit n level n
// (R9) Enable by software; detect by software, interrupts
// (R10) Run highest level set in both masks
// (R11) Upward change only by a request
// (R12) Downward change when running level gives up
// (R13) Register access uses running level's set
// (R14) Status bits 8-11 hold running level
// (R15) Status bits 0-7 hold the flags
// (R16) Status bit 15 is interrupt-on
// (R17) Status bit 14 is memory-management-on
// (R18) Level change only at instruction boundary
`ifndef PLC_REGS_SVH
`define PLC_REGS_SVH
`define PLC_ADDR_ENABLE 4'h0
`define PLC_ADDR_REQUEST 4'h1
`define PLC_ADDR_STATUS 4'h2
`define PLC_ADDR_SET_REQ 4'h3
`define PLC_ADDR_CLR_REQ 4'h4
`define PLC_ADDR_GIVE_UP 4'h5
`define PLC_ADDR_EVT 4'h6
`define PLC_ADDR_EVT_MASK 4'h7
`define PLC_ADDR_LEVEL 4'h8
`define PLC_ADDR_GREG 4'h9
`define PLC_ADDR_GSEL 4'hA
`define PLC_EXT_LEVELS 16'hBC00
`define PLC_INT_LEVEL 4'hE
`define PLC_LVL_LSB 8
`define PLC_MMU_BIT 14
`define PLC_IRQ_BIT 15
`define PLC_FLAG_MASK 16'h00FF
`define PLC_STS_RESET 16'h0000
`define PLC_SWITCH_NS 1000
`define PLC_CLK_NS 50
`define PLC_SWITCH_CYC ((`PLC_SWITCH_NS) / (`PLC_CLK_NS))
`define PLC_SWITCH_LAST ((`PLC_SWITCH_CYC) - 2)
`endif

// ### tb/plc_ctrl_checker.sv
// Port assertions for the program level controller
`timescale 1ns/1ps
module plc_ctrl_checker (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire plc_pkg::plc_level_t vec_level_i,
    input wire plc_pkg::plc_vector_t vec_id_i,
    input wire logic instr_boundary_i,
    input wire plc_pkg::plc_level_t current_level_o,
    input wire logic switching_o,
    input wire plc_pkg::plc_vector_t last_vector_o,
    input wire plc_pkg::plc_word_t processor_status_word_o
);
    import plc_pkg::*;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    chk_level_field: assert property (processor_status_word_o[11:8] == current_level_o)
        else $error("status level field differs");
    chk_spare_bits: assert property (processor_status_word_o[13:12] == 2'b00)
        else $error("status spare bits set");
    chk_switch_time: assert property ($rose(switching_o) |-> ##[1:21] !switching_o)
        else $error("switch too slow");
    chk_switch_long: assert property ($rose(switching_o) |=> switching_o[*8])
        else $error("switch cut short");
    chk_switch_start: assert property ($rose(switching_o) |-> $past(instr_boundary_i))
        else $error("switch began off a boundary");
    chk_level_moves: assert property ($changed(current_level_o) |-> $past(switching_o))
        else $error("level changed without switch");
    chk_vec_level: assert property ($changed(last_vector_o) |->
        vec_level_i inside {4'hA, 4'hB, 4'hC, 4'hD, 4'hF})
        else $error("vector taken for bad level");
    chk_vec_id: assert property ($changed(last_vector_o) |-> last_vector_o == vec_id_i)
        else $error("vector id mismatch");
endmodule : plc_ctrl_checker
bind plc_ctrl plc_ctrl_checker u_chk (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .vec_level_i(vec_level_i), .vec_id_i(vec_id_i), .instr_boundary_i(instr_boundary_i),
    .current_level_o(current_level_o), .switching_o(switching_o),
    .last_vector_o(last_vector_o), .processor_status_word_o(processor_status_word_o));

// ### tb/plc_dev_model.sv
// Model of an external device raising vectored requests
`timescale 1ns/1ps
module plc_dev_model (
    input wire logic clk_i,
    input wire logic go_i,
    input wire plc_pkg::plc_level_t lvl_i,
    input wire plc_pkg::plc_vector_t id_i,
    output logic vec_req_o,
    output plc_pkg::plc_level_t vec_level_o = 4'h0,
    output plc_pkg::plc_vector_t vec_id_o = 11'h000
);
    int cnt = 0;
    // Level and id are held stable well around the request edge
    always @(posedge clk_i) begin
        if (go_i) begin
            vec_level_o <= lvl_i;
            vec_id_o <= id_i;
            cnt <= 10;
        end else if (cnt > 0) begin
            cnt <= cnt - 1;
        end
    end
    assign vec_req_o = (cnt > 0) && (cnt < 8);
endmodule : plc_dev_model

// ### tb/test_program_level_priority_control.sv
// Self-checking bench for the program level controller
`timescale 1ns/1ps
`include "plc_regs.svh"
module test_program_level_priority_control;
    import plc_pkg::*;
    logic clk_i = 0, rst_b_i = 0, wr = 0, rd = 0, int_st = 0, bnd = 1, go = 0, vreq, sw, irq;
    logic [3:0] addr = 4'h0;
    plc_word_t wdata = 16'h0000, rdata, psw;
    plc_level_t glvl = 4'h0, vlvl, lvl;
    plc_vector_t gid = 11'h000, vid, lastv;
    int fail_count = 0, checks_done = 0, cyc = 0;
    always #25 clk_i = ~clk_i;
    plc_ctrl uut (.clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
        .rd_i(rd), .rdata_o(rdata), .vec_req_i(vreq), .vec_level_i(vlvl), .vec_id_i(vid),
        .int_status_i(int_st), .instr_boundary_i(bnd), .current_level_o(lvl),
        .switching_o(sw), .last_vector_o(lastv), .processor_status_word_o(psw), .irq_o(irq));
    plc_dev_model dev (.clk_i(clk_i), .go_i(go), .lvl_i(glvl), .id_i(gid), .vec_req_o(vreq),
        .vec_level_o(vlvl), .vec_id_o(vid));
    task chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task wreg(input logic [3:0] a, input plc_word_t d);
        @(posedge clk_i);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_i);
        wr <= 1'b0;
    endtask : wreg
    task rreg(input logic [3:0] a, input plc_word_t e);
        @(posedge clk_i);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_i);
        rd <= 1'b0;
        #1 chk(rdata, e);
    endtask : rreg
    // Bounded wait, the switch itself takes about twenty cycles
    task wait_lvl(input plc_level_t l);
        for (int i = 0; i < 100 && lvl !== l; i++) begin
            @(posedge clk_i);
            #1;
        end
        chk({12'h000, lvl}, {12'h000, l});
    endtask : wait_lvl
    task fire(input plc_level_t l, input plc_vector_t id);
        @(posedge clk_i);
        glvl <= l;
        gid <= id;
        go <= 1'b1;
        @(posedge clk_i);
        go <= 1'b0;
        repeat (15) @(posedge clk_i);
    endtask : fire
    task s_reset;
        rreg(`PLC_ADDR_ENABLE, 16'h0000);
        rreg(`PLC_ADDR_REQUEST, 16'h0000);
        rreg(`PLC_ADDR_STATUS, 16'h0000);
        rreg(4'hF, 16'h0000);
    endtask : s_reset
    task s_vector;
        wreg(`PLC_ADDR_ENABLE, 16'hFFFF);
        wreg(`PLC_ADDR_EVT_MASK, 16'h0003);
        fire(4'hC, 11'h5A5);
        wait_lvl(4'hC);
        chk({5'h00, lastv}, 16'h05A5);
        chk({15'h0000, irq}, 16'h0001);
        rreg(`PLC_ADDR_EVT, 16'h0003);
        repeat (2) @(posedge clk_i);
        #1 chk({15'h0000, irq}, 16'h0000);
    endtask : s_vector
    task s_refuse;
        fire(4'h5, 11'h001);
        rreg(`PLC_ADDR_REQUEST, 16'h1000);
        chk({5'h00, lastv}, 16'h05A5);
    endtask : s_refuse
    task s_bank;
        @(posedge clk_i);
        int_st <= 1'b1;
        wait_lvl(4'hE);
        @(posedge clk_i);
        int_st <= 1'b0;
        wreg(`PLC_ADDR_GSEL, 16'h0002);
        wreg(`PLC_ADDR_GREG, 16'h1234);
        wreg(`PLC_ADDR_GIVE_UP, 16'h0000);
        wait_lvl(4'hC);
        rreg(`PLC_ADDR_GREG, 16'h0000);
        wreg(`PLC_ADDR_SET_REQ, 16'h4000);
        wait_lvl(4'hE);
        rreg(`PLC_ADDR_GREG, 16'h1234);
    endtask : s_bank
    task s_low;
        @(posedge clk_i);
        bnd <= 1'b0;
        wreg(`PLC_ADDR_CLR_REQ, 16'hFFFF);
        wreg(`PLC_ADDR_SET_REQ, 16'h0009);
        repeat (30) @(posedge clk_i);
        #1 chk({12'h000, lvl}, 16'h000E);
        @(posedge clk_i);
        bnd <= 1'b1;
        wait_lvl(4'h3);
        wreg(`PLC_ADDR_STATUS, 16'hFFA5);
        #1 chk(psw, 16'hC3A5);
        rreg(`PLC_ADDR_STATUS, 16'hC3A5);
    endtask : s_low
    task results;
        $display("fails=%0d checks=%0d", fail_count, checks_done);
        if (fail_count == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : results
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 5000) begin
            fail_count++;
            results();
        end
    end
    initial begin
        repeat (6) @(posedge clk_i);
        rst_b_i <= 1'b1;
        s_reset();
        s_vector();
        s_refuse();
        s_bank();
        s_low();
        results();
    end
endmodule : test_program_level_priority_control
